// File: dv/double_precision_float_unit_tb_top.sv
`timescale 1ns/1ns
module double_precision_float_unit_tb_top;
    typedef struct {
        dpf_pkg::dpf_op_e o;
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] r;
        logic [3:0] f;
        int t;
    } dpf_case_s;
    // operation, operand tops, result top, flags, cycles (0 = not timed)
    dpf_case_s cases [13] = '{
        '{dpf_pkg::OP_ADD, 16'h4110, 16'h4110, 16'h4120, 4'h2, 19},
        '{dpf_pkg::OP_ADD, 16'h41F0, 16'h41F0, 16'h421E, 4'h2, 0},
        '{dpf_pkg::OP_SUB, 16'h4120, 16'h4010, 16'h411F, 4'h2, 22},
        '{dpf_pkg::OP_SUB, 16'h4110, 16'h4120, 16'hC110, 4'h1, 19},
        '{dpf_pkg::OP_ADD, 16'h4F10, 16'h4010, 16'h4F10, 4'h2, 58},
        '{dpf_pkg::OP_MUL, 16'hC110, 16'h4120, 16'hC120, 4'h1, 45},
        '{dpf_pkg::OP_MUL, 16'h7F10, 16'h7F10, 16'h7FFF, 4'h6, 45},
        '{dpf_pkg::OP_MUL, 16'h0110, 16'h0110, 16'h0000, 4'h4, 45},
        '{dpf_pkg::OP_DIV, 16'h4120, 16'h4110, 16'h4120, 4'h2, 186},
        '{dpf_pkg::OP_DIV, 16'h4120, 16'h0000, 16'h4120, 4'hC, 186},
        '{dpf_pkg::OP_CMP, 16'hC110, 16'h4110, 16'hC110, 4'h9, 10},
        '{dpf_pkg::OP_CMP, 16'h4120, 16'h4110, 16'h4120, 4'h2, 10},
        '{dpf_pkg::OP_CMP, 16'h4110, 16'h4110, 16'h4110, 4'h0, 10}
    };
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic go = 1'b0;
    dpf_pkg::dpf_uop_s cmd = '0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic uop_valid, stall_ff, rd_valid_ff, irq_ff;
    dpf_pkg::dpf_uop_s uop;
    dpf_pkg::dpf_flags_s cc_ff;
    logic [31:0] rd_data_ff, rdata_ff, rv;
    logic [63:0] q, e;
    int bad_count = 0;
    int num_checks = 0;
    int n, nf;
    // 25 MHz clock
    always #20 clk = ~clk;
    // design and issuing sequencer
    dpf_float_unit DUT (.clk(clk), .reset(reset), .uop_valid(uop_valid), .uop(uop), .stall_ff(stall_ff),
        .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .cc_ff(cc_ff), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .irq_ff(irq_ff));
    dpf_seq_model u_seq (.clk(clk), .reset(reset), .go(go), .cmd(cmd), .stall_ff(stall_ff),
        .uop_valid(uop_valid), .uop(uop));
    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic hang();
        $display("wait limit reached");
        bad_count++;
        complete_run();
    endtask
    // compare a value, and a cycle count
    task automatic chk_v(string nm, logic [63:0] x, logic [63:0] g);
        num_checks++;
        if (g !== x) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic chk_n(string nm, int x, int g);
        chk_v(nm, 64'(x), 64'(g));
    endtask
    // register port cycles
    task automatic reg_wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata_ff;
    endtask
    // issue one micro-instruction; w waits for completion and counts busy cycles
    task automatic op(dpf_pkg::dpf_op_e o, logic [2:0] a, logic [2:0] b, logic x, logic h, logic [63:0] d, bit w);
        int i;
        @(posedge clk);
        cmd <= '{o, a, b, h, x, d};
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        #1;
        for (i = 0; stall_ff === 1'b1; i++) begin
            if (i == 400) hang();
            @(posedge clk) #1;
        end
        @(posedge clk) #1;
        n = 0;
        while (w && stall_ff === 1'b1) begin
            n++;
            if (n == 400) hang();
            @(posedge clk) #1;
        end
        if (w && (o == dpf_pkg::OP_READ || o == dpf_pkg::OP_RDCC)) begin
            chk_v("read valid", 64'h1, {63'h0, rd_valid_ff});
            rv = rd_data_ff;
        end
    endtask
    // both halves of a double register, cycles of the first read
    task automatic rd64(logic [2:0] b);
        op(dpf_pkg::OP_READ, 3'h0, b, 1'b0, 1'b0, 64'h0, 1'b1);
        nf = n;
        q[63:32] = rv;
        op(dpf_pkg::OP_READ, 3'h0, b, 1'b0, 1'b1, 64'h0, 1'b1);
        q[31:0] = rv;
    endtask
    // load, then collect final flags and value
    task automatic load_case(logic [63:0] d, logic [63:0] r, logic [3:0] f, int t);
        op(dpf_pkg::OP_LOAD, 3'h2, 3'h0, 1'b1, 1'b0, d, 1'b1);
        chk_n("load cycles", t, n);
        op(dpf_pkg::OP_RDCC, 3'h0, 3'h0, 1'b0, 1'b0, 64'h0, 1'b1);
        chk_v("load flags", {60'h0, f}, {32'h0, rv});
        rd64(3'h2);
        chk_v("load value", r, q);
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        reg_rd(dpf_pkg::REG_CTRL, rv);
        chk_v("ctrl", 64'h1, {32'h0, rv});
        reg_rd(8'h10, rv);
        chk_v("unmapped", 64'h0, {32'h0, rv});
        reg_wr(dpf_pkg::REG_MASK, 32'h1);
        load_case(64'h4110000000000000, 64'h4110000000000000, 4'h2, 8);
        load_case(64'hC100100000000000, 64'hBF10000000000000, 4'h1, 14);
        op(dpf_pkg::OP_LOAD, 3'h2, 3'h0, 1'b1, 1'b0, 64'h0, 1'b0);
        @(posedge clk) #1;
        chk_v("zero load early flags", 64'h4, {60'h0, cc_ff});
        op(dpf_pkg::OP_RDCC, 3'h0, 3'h0, 1'b0, 1'b0, 64'h0, 1'b1);
        chk_v("zero load flags", 64'h0, {32'h0, rv});
        foreach (cases[k]) begin
            op(dpf_pkg::OP_LOAD, 3'h1, 3'h0, 1'b1, 1'b0, {cases[k].a, 48'h0}, 1'b1);
            op(cases[k].o, 3'h1, 3'h0, 1'b1, 1'b0, {cases[k].b, 48'h0}, 1'b1);
            if (cases[k].t > 0) chk_n("op cycles", cases[k].t, n);
            rd64(3'h1);
            chk_n("read cycles", cases[k].o == dpf_pkg::OP_CMP ? 6 : 2, nf);
            e = {cases[k].r, cases[k].r == 16'h7FFF ? 48'hFFFFFFFFFFFF : 48'h0};
            chk_v("result", e, q);
            chk_v("flags", {60'h0, cases[k].f}, {60'h0, cc_ff});
        end
        reg_rd(dpf_pkg::REG_STATUS, rv);
        chk_v("status events", 64'hF, {32'h0, rv});
        op(dpf_pkg::OP_LOAD, 3'h4, 3'h0, 1'b1, 1'b0, 64'h4110000000000000, 1'b1);
        op(dpf_pkg::OP_MUL, 3'h4, 3'h0, 1'b1, 1'b0, 64'h4120000000000000, 1'b0);
        op(dpf_pkg::OP_READ, 3'h0, 3'h4, 1'b0, 1'b0, 64'h0, 1'b1);
        chk_v("read during multiply", 64'h41200000, {32'h0, rv});
        chk_v("irq raised", 64'h1, {63'h0, irq_ff});
        reg_rd(dpf_pkg::REG_STATUS, rv);
        chk_v("status", 64'h1, {32'h0, rv});
        repeat (2) @(posedge clk);
        #1 chk_v("irq cleared", 64'h0, {63'h0, irq_ff});
        reg_wr(dpf_pkg::REG_MASK, 32'h0);
        op(dpf_pkg::OP_ADD, 3'h4, 3'h0, 1'b1, 1'b0, 64'h4110000000000000, 1'b1);
        repeat (2) @(posedge clk);
        #1 chk_v("irq masked", 64'h0, {63'h0, irq_ff});
        reg_rd(dpf_pkg::REG_STATE, rv);
        chk_v("state", 64'h32, {32'h0, rv});
        reg_wr(dpf_pkg::REG_CTRL, 32'h0);
        @(posedge clk) #1;
        chk_v("disabled stall", 64'h1, {63'h0, stall_ff});
        reg_wr(dpf_pkg::REG_CTRL, 32'h1);
        complete_run();
    end
endmodule

// File: dv/dpf_float_unit_properties.sv
`timescale 1ns/1ns
module dpf_float_unit_properties (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // micro-instruction port
    input wire logic uop_valid,
    input wire dpf_pkg::dpf_uop_s uop,
    input wire logic stall_ff,
    // read results and flags
    input wire logic [31:0] rd_data_ff,
    input wire logic rd_valid_ff,
    input wire dpf_pkg::dpf_flags_s cc_ff
);
    logic take;
    dpf_pkg::dpf_op_e last_op_ff;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // request accepted at this edge
    assign take = uop_valid && !stall_ff;
    // last accepted operation
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            last_op_ff <= dpf_pkg::OP_LOAD;
        end else if (take) begin
            last_op_ff <= uop.op;
        end
    end
    chk_load_flags: assert property (
        take && uop.op == dpf_pkg::OP_LOAD |-> ##2 !cc_ff.c && (cc_ff.v ? !(cc_ff.g || cc_ff.l) : cc_ff.g != cc_ff.l))
        else $error("load flags wrong");
    chk_rdcc_data: assert property (
        rd_valid_ff && last_op_ff == dpf_pkg::OP_RDCC |-> rd_data_ff == {28'h0, cc_ff})
        else $error("condition read data wrong");
    chk_read_cc: assert property (
        take && uop.op == dpf_pkg::OP_READ |=> $stable(cc_ff) [*4]) else $error("read changed flags");
    chk_read_fast: assert property (
        take && uop.op == dpf_pkg::OP_READ && last_op_ff inside {dpf_pkg::OP_ADD, dpf_pkg::OP_SUB,
        dpf_pkg::OP_MUL, dpf_pkg::OP_DIV} |-> ##2 stall_ff ##1 !stall_ff) else $error("fast read timing wrong");
    chk_cmp_time: assert property (
        take && uop.op == dpf_pkg::OP_CMP |-> ##10 stall_ff ##1 !stall_ff ##0
        (cc_ff == 4'h0 || cc_ff == 4'h9 || cc_ff == 4'h2)) else $error("compare timing or flags wrong");
    chk_carry_code: assert property (
        cc_ff.c |-> cc_ff == 4'h9 || cc_ff == 4'hC) else $error("carry flag in wrong code");
    chk_add_time: assert property (
        take && uop.op inside {dpf_pkg::OP_ADD, dpf_pkg::OP_SUB} |-> ##19 stall_ff ##[1:40] !stall_ff)
        else $error("add timing wrong");
    chk_mul_time: assert property (
        take && uop.op == dpf_pkg::OP_MUL |-> ##45 stall_ff ##[1:61] !stall_ff) else $error("multiply timing wrong");
    chk_read_done: assert property (
        rd_valid_ff |-> !stall_ff) else $error("read returned while busy");
endmodule
bind dpf_float_unit dpf_float_unit_properties u_props (.clk(clk), .reset(reset), .uop_valid(uop_valid),
    .uop(uop), .stall_ff(stall_ff), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .cc_ff(cc_ff));

// File: dv/dpf_seq_model.sv
`timescale 1ns/1ns
module dpf_seq_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // request from the bench
    input wire logic go,
    input wire dpf_pkg::dpf_uop_s cmd,
    // micro-instruction port
    input wire logic stall_ff,
    output logic uop_valid,
    output dpf_pkg::dpf_uop_s uop
);
    // hold a request until it is taken, then scramble the idle bus
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            uop_valid <= 1'b0;
            uop <= '0;
        end else if (go) begin
            uop_valid <= 1'b1;
            uop <= cmd; // destination field carries only a double register index
        end else if (!uop_valid || !stall_ff) begin
            uop_valid <= 1'b0;
            uop <= dpf_pkg::dpf_uop_s'(~uop);
        end
    end
endmodule

// File: hdl/dpf_arith.sv
`timescale 1ns/1ns
module dpf_arith (
    // operation and operands
    input wire dpf_pkg::dpf_op_e op,
    input wire logic [63:0] a,
    input wire logic [63:0] b,
    // result
    output logic [63:0] res,
    output dpf_pkg::dpf_flags_s fl,
    output dpf_pkg::dpf_flags_s load_fl,
    output logic wr,
    output logic [7:0] cyc
);
    logic [55:0] fa;
    logic [55:0] fb;
    logic [6:0] ea;
    logic [6:0] eb;
    logic sa;
    logic sb;
    logic sr;
    logic a_big;
    logic [6:0] dexp;
    logic [3:0] esh;
    logic [63:0] wbig;
    logic [63:0] wsml;
    logic [63:0] w;
    logic [63:0] wn;
    logic [9:0] e;
    logic [9:0] en;
    logic [3:0] nz;
    logic found;
    logic [4:0] steps;
    logic [111:0] prod;
    logic [115:0] quot;

    assign fa = a[55:0];
    assign fb = b[55:0];
    assign ea = a[62:56];
    assign eb = b[62:56];
    assign prod = fa * fb;
    assign quot = (fb == 56'h0) ? 116'h0 : {fa, 60'h0} / {60'h0, fb};

    // datapath: align, combine, carry and normalize
    always_comb begin
        sa = a[63];
        sb = b[63] ^ (op == dpf_pkg::OP_SUB);
        a_big = (a[62:0] >= b[62:0]);
        dexp = a_big ? (ea - eb) : (eb - ea);
        esh = (dexp > 7'(dpf_pkg::MAX_SHIFT)) ? 4'hE : dexp[3:0];
        wbig = {4'h0, a_big ? fa : fb, 4'h0};
        wsml = {4'h0, a_big ? fb : fa, 4'h0};
        wsml = (esh == 4'hE) ? 64'h0 : (wsml >> {esh, 2'b00});
        w = 64'h0;
        e = 10'h0;
        sr = 1'b0;
        wr = 1'b0;
        cyc = dpf_pkg::RD_CYC;
        case (op)
            dpf_pkg::OP_LOAD: begin
                w = {4'h0, fb, 4'h0};
                e = {3'h0, eb};
                sr = b[63];
                wr = 1'b1;
            end
            dpf_pkg::OP_ADD, dpf_pkg::OP_SUB: begin
                w = (sa ^ sb) ? (wbig - wsml) : (wbig + wsml);
                e = {3'h0, a_big ? ea : eb};
                sr = a_big ? sa : sb;
                wr = 1'b1;
            end
            dpf_pkg::OP_MUL: begin
                w = {4'h0, prod[111:52]};
                e = {3'h0, ea} + {3'h0, eb} - dpf_pkg::EXP_BIAS;
                sr = a[63] ^ b[63];
                wr = 1'b1;
            end
            dpf_pkg::OP_DIV: begin
                w = quot[63:0];
                e = {3'h0, ea} - {3'h0, eb} + dpf_pkg::EXP_BIAS;
                sr = a[63] ^ b[63];
                wr = (fb != 56'h0);
            end
            default: begin
                w = 64'h0;
            end
        endcase
        // carry out of the fraction: one digit right
        if (w[63:60] != 4'h0) begin
            w = w >> 4;
            e = e + 10'h001;
        end
        nz = 4'h0;
        found = 1'b0;
        for (int i = 13; i >= 0; i--) begin
            if (!found && w[4 + 4 * i +: 4] == 4'h0) begin
                nz = nz + 4'h1;
            end else begin
                found = 1'b1;
            end
        end
        if (nz == 4'hE) begin
            nz = 4'h0;
        end
        wn = w << {nz, 2'b00};
        en = e - {6'h0, nz};
        // result fields and flags
        res = {sr, en[6:0], wn[59:4]};
        fl = {2'b00, ~sr, sr};
        if (w[59:4] == 56'h0) begin
            res = 64'h0;
            fl = 4'h0;
        end else if (en[9]) begin
            res = 64'h0;
            fl = 4'h4;
        end else if (en > dpf_pkg::EXP_MAX) begin
            res = {sr, 63'h7FFFFFFFFFFFFFFF};
            fl = {2'b01, ~sr, sr};
        end
        if (op == dpf_pkg::OP_DIV && fb == 56'h0) begin
            fl = 4'hC;
        end
        // algebraic compare
        if (op == dpf_pkg::OP_CMP) begin
            if (a == b || (fa == 56'h0 && fb == 56'h0)) begin
                fl = 4'h0;
            end else if (a[63] != b[63] ? a[63] : (a[63] ^ (a[62:0] < b[62:0]))) begin
                fl = 4'h9;
            end else begin
                fl = 4'h2;
            end
        end
        // timing
        steps = {1'b0, (esh > dpf_pkg::MAX_SHIFT) ? dpf_pkg::MAX_SHIFT : esh} + {1'b0, nz};
        if (steps > {1'b0, dpf_pkg::MAX_SHIFT}) begin
            steps = {1'b0, dpf_pkg::MAX_SHIFT};
        end
        case (op)
            dpf_pkg::OP_LOAD: cyc = dpf_pkg::LOAD_CYC + 8'(dpf_pkg::STEP_CYC * nz);
            dpf_pkg::OP_CMP: cyc = dpf_pkg::CMP_CYC;
            dpf_pkg::OP_ADD, dpf_pkg::OP_SUB: cyc = dpf_pkg::ADD_CYC + 8'(dpf_pkg::STEP_CYC * steps);
            dpf_pkg::OP_MUL: cyc = dpf_pkg::MUL_CYC
                + ((fa[27:0] != 28'h0) ? dpf_pkg::MUL_STEP_CYC : 8'h00)
                + ((fb[27:0] != 28'h0) ? dpf_pkg::MUL_STEP_CYC : 8'h00);
            dpf_pkg::OP_DIV: cyc = dpf_pkg::DIV_CYC;
            default: cyc = dpf_pkg::RD_CYC;
        endcase
        // immediate load flags: overflow flag marks an unnormalized argument
        load_fl = (fb[55:52] != 4'h0) ? {2'b00, ~b[63], b[63]} : 4'h4;
    end

endmodule

// File: hdl/dpf_float_unit.sv
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module dpf_float_unit (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // micro-instruction port
    input wire logic uop_valid,
    input wire dpf_pkg::dpf_uop_s uop,
    output logic stall_ff,
    // read results and condition flags
    output logic [31:0] rd_data_ff,
    output logic rd_valid_ff,
    output dpf_pkg::dpf_flags_s cc_ff,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata_ff,
    // interrupt
    output logic irq_ff
);

    // double registers
    logic [63:0] regs_ff [dpf_pkg::REG_N];

    // operation in progress
    logic busy_ff;
    logic [7:0] cnt_ff;
    dpf_pkg::dpf_op_e op_ff;
    logic [2:0] dst_ff;
    logic [63:0] res_ff;
    dpf_pkg::dpf_flags_s fl_ff;
    logic wr_ff;
    logic [31:0] half_ff;
    logic last_long_ff;

    // software registers
    logic [3:0] status_ff;
    logic [3:0] mask_ff;
    logic ctrl_en_ff;

    // arithmetic results
    logic [63:0] a_op;
    logic [63:0] b_op;
    logic [63:0] ar_res;
    dpf_pkg::dpf_flags_s ar_fl;
    dpf_pkg::dpf_flags_s ar_load_fl;
    logic ar_wr;
    logic [7:0] ar_cyc;

    // control terms
    logic take;
    logic done;
    logic nxt_busy;
    logic op_long;
    logic op_reads;
    logic [3:0] ev;
    logic st_clr;
    logic [3:0] nxt_status;

    // operand selection
    assign a_op = regs_ff[uop.a_sel];
    assign b_op = uop.b_ext ? uop.b_data : regs_ff[uop.b_sel];

    // a micro-instruction is taken only while not stalled
    assign take = uop_valid && !stall_ff;
    assign done = busy_ff && (cnt_ff == 8'h00);
    assign nxt_busy = take || (busy_ff && !done);

    // classes of the operation in progress
    assign op_long = (op_ff == dpf_pkg::OP_ADD) || (op_ff == dpf_pkg::OP_SUB)
        || (op_ff == dpf_pkg::OP_MUL) || (op_ff == dpf_pkg::OP_DIV);
    assign op_reads = (op_ff == dpf_pkg::OP_READ) || (op_ff == dpf_pkg::OP_RDCC);

    dpf_arith u_arith (
        .op(uop.op),
        .a(a_op),
        .b(b_op),
        .res(ar_res),
        .fl(ar_fl),
        .load_fl(ar_load_fl),
        .wr(ar_wr),
        .cyc(ar_cyc)
    );

    // stall while busy or disabled
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stall_ff <= 1'b1;
        end else begin
            stall_ff <= nxt_busy || !ctrl_en_ff;
        end
    end

    // busy flag and cycle counter
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_ff <= 1'b0;
            cnt_ff <= 8'h00;
        end else if (take) begin
            busy_ff <= 1'b1;
            if (uop.op == dpf_pkg::OP_READ && last_long_ff) begin
                cnt_ff <= dpf_pkg::RD_FAST_CYC - 8'h01;
            end else begin
                cnt_ff <= ar_cyc - 8'h01;
            end
        end else if (done) begin
            busy_ff <= 1'b0;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end

    // latch the operation outcome when it is taken
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            op_ff <= dpf_pkg::OP_READ;
            dst_ff <= 3'h0;
            res_ff <= 64'h0;
            fl_ff <= 4'h0;
            wr_ff <= 1'b0;
            half_ff <= 32'h0;
        end else if (take) begin
            op_ff <= uop.op;
            dst_ff <= uop.a_sel;
            res_ff <= ar_res;
            fl_ff <= ar_fl;
            wr_ff <= ar_wr && (uop.op != dpf_pkg::OP_READ) && (uop.op != dpf_pkg::OP_RDCC);
            half_ff <= uop.b_half ? b_op[31:0] : b_op[63:32];
        end
    end

    // register file write at the end of the operation
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < dpf_pkg::REG_N; i++) begin
                regs_ff[i] <= 64'h0;
            end
        end else if (done && wr_ff) begin
            regs_ff[dst_ff] <= res_ff;
        end
    end

    // condition flags
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cc_ff <= 4'h0;
        end else if (take && uop.op == dpf_pkg::OP_LOAD) begin
            cc_ff <= ar_load_fl;
        end else if (done && !op_reads) begin
            cc_ff <= fl_ff;
        end
    end

    // remember whether the last operation was a long one
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            last_long_ff <= 1'b0;
        end else if (done) begin
            last_long_ff <= op_long;
        end
    end

    // read results appear once the unit is idle again
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_valid_ff <= 1'b0;
            rd_data_ff <= 32'h0;
        end else begin
            rd_valid_ff <= done && op_reads;
            if (done && op_ff == dpf_pkg::OP_READ) begin
                rd_data_ff <= half_ff;
            end else if (done && op_ff == dpf_pkg::OP_RDCC) begin
                rd_data_ff <= {28'h0, cc_ff};
            end
        end
    end

    // events raised as an operation finishes
    always_comb begin
        ev = 4'h0;
        if (done && !op_reads) begin
            ev[dpf_pkg::ST_DONE] = 1'b1;
            ev[dpf_pkg::ST_OVF] = !fl_ff.c && fl_ff.v && (fl_ff.g || fl_ff.l);
            ev[dpf_pkg::ST_UNF] = (fl_ff == 4'h4);
            ev[dpf_pkg::ST_DZ] = fl_ff.c && fl_ff.v;
        end
    end

    // sticky status: a read clears, a new event wins
    assign st_clr = rd && (addr == dpf_pkg::REG_STATUS);
    assign nxt_status = (st_clr ? 4'h0 : status_ff) | ev;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_ff <= 4'h0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // mask and control writes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mask_ff <= dpf_pkg::MASK_RST;
            ctrl_en_ff <= dpf_pkg::CTRL_EN_RST;
        end else if (wr) begin
            if (addr == dpf_pkg::REG_MASK) begin
                mask_ff <= wdata[3:0];
            end
            if (addr == dpf_pkg::REG_CTRL) begin
                ctrl_en_ff <= wdata[0];
            end
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= 32'h0;
        end else if (rd) begin
            case (addr)
                dpf_pkg::REG_STATUS: rdata_ff <= {28'h0, status_ff};
                dpf_pkg::REG_MASK: rdata_ff <= {28'h0, mask_ff};
                dpf_pkg::REG_CTRL: rdata_ff <= {31'h0, ctrl_en_ff};
                dpf_pkg::REG_STATE: rdata_ff <= {24'h0, busy_ff, op_ff, cc_ff};
                default: rdata_ff <= 32'h0;
            endcase
        end
    end

    // level interrupt from unmasked status
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_status & mask_ff);
        end
    end

endmodule

// File: hdl/dpf_pkg.sv
package dpf_pkg;

    // machine timing
    localparam int CLK_NS = 40;
    localparam int LOAD_NS = 320;
    localparam int STEP_NS = 100;
    localparam int RD_NS = 240;
    localparam int RD_FAST_NS = 60;
    localparam int CMP_NS = 400;
    localparam int ADD_NS = 750;
    localparam int MUL_BEST_NS = 1800;
    localparam int MUL_STEP_NS = 1200;
    localparam int DIV_NS = 7420;

    // least times, rounded up to whole cycles
    localparam logic [7:0] LOAD_CYC = 8'((LOAD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] STEP_CYC = 8'((STEP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] RD_CYC = 8'((RD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] RD_FAST_CYC = 8'((RD_FAST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] CMP_CYC = 8'((CMP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] ADD_CYC = 8'((ADD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] MUL_CYC = 8'((MUL_BEST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] MUL_STEP_CYC = 8'((MUL_STEP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] DIV_CYC = 8'((DIV_NS + CLK_NS - 1) / CLK_NS);

    // number format and limits
    localparam logic [3:0] MAX_SHIFT = 4'hD;
    localparam logic [9:0] EXP_BIAS = 10'h040;
    localparam logic [9:0] EXP_MAX = 10'h07F;
    localparam int REG_N = 8;

    // register offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_STATE = 8'h0C;

    // status bit positions and reset values
    localparam int ST_DONE = 0;
    localparam int ST_OVF = 1;
    localparam int ST_UNF = 2;
    localparam int ST_DZ = 3;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic CTRL_EN_RST = 1'b1;

    typedef enum logic [2:0] {
        OP_LOAD = 3'h0,
        OP_READ = 3'h1,
        OP_CMP = 3'h2,
        OP_ADD = 3'h3,
        OP_SUB = 3'h4,
        OP_MUL = 3'h5,
        OP_DIV = 3'h6,
        OP_RDCC = 3'h7
    } dpf_op_e;

    typedef struct packed {
        dpf_op_e op;
        logic [2:0] a_sel;
        logic [2:0] b_sel;
        logic b_half;
        logic b_ext;
        logic [63:0] b_data;
    } dpf_uop_s;

    typedef struct packed {
        logic c;
        logic v;
        logic g;
        logic l;
    } dpf_flags_s;

endpackage
